/* core/tsio_regs.vh */
`ifndef TSIO_REGS_VH
`define TSIO_REGS_VH
// register byte addresses on the apb
`define TSIO_P7_DIR_ADDR 12'h000
`define TSIO_P7_DATA_ADDR 12'h004
`define TSIO_P8_DIR_ADDR 12'h008
`define TSIO_P8_DATA_ADDR 12'h00c
`define TSIO_P7_PIN_ADDR 12'h010
`define TSIO_P8_PIN_ADDR 12'h014
// port 7 field layout
`define TSIO_P7_LSB 4
`define TSIO_P7_MSB 6
`define TSIO_P7_RSV_MASK 8'h8f
// reset values
`define TSIO_P7_DIR_RST 3'h0
`define TSIO_P7_DATA_RST 3'h0
`define TSIO_P8_DIR_RST 8'h00
`define TSIO_P8_DATA_RST 8'h00
// small timer output select value that leaves the pin to the port
`define TSIO_OS_PORT 4'h0
`endif

/* core/tsio_sync.v */
`timescale 1ns/10ps
// two-flop synchroniser, a vector of independent bits
module tsio_sync
#(
   parameter WIDTH = 8
)
(
   input wire pclk, // system clock
   input wire presetn, // async reset, active low
   input wire [WIDTH-1:0] d, // asynchronous levels
   output reg [WIDTH-1:0] q // synchronised levels
);
   reg [WIDTH-1:0] meta_q;

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         meta_q <= {WIDTH{1'b0}};
         q <= {WIDTH{1'b0}};
      end
      else
      begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule // tsio_sync

/* core/tsio_ports.v */
// Summary of operation
// - port 7 data bits 7 and 3..0 are reserved, reset to 1 and read as 1.
// - port 7 data bits 6..4 hold pin output values, read/write, reset 0.
// - a port 7 data bit read with its direction 1 returns the latch.
// - a port 7 data bit read with its direction 0 returns the pin level.
// - pin 7.6 is port I/O only while the small timer select is 0000.
// - pins 7.5 and 7.4 follow their direction and always feed timer inputs.
// - port 7 direction bits 6..4 are write-only, reset 0, 1 means output.
// - for pins 8.4..8.1 the wide timer setting beats port direction/data.
// - pin 8.0 always feeds the wide timer clock input and stays port I/O.
// - port 8 direction is eight write-only bits, reset 0, 1 means output.
// - port 8 data holds eight read/write output bits, reset 0.
// - a port 8 data bit read with its direction 1 returns the latch.
// - a port 8 data bit read with its direction 0 returns the pin level.
// - pin 8.4 is pwm out, else timer out on codes 001/01x, else port I/O.
//
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
`include "tsio_regs.vh"
module tsio_ports
(
   input wire pclk, // system clock
   input wire presetn, // async reset, active low
   input wire psel, // apb select
   input wire penable, // apb access phase
   input wire pwrite, // apb direction
   input wire [11:0] paddr, // apb byte address
   input wire [31:0] pwdata, // apb write data
   output reg [31:0] prdata, // apb read data
   output reg pready, // apb ready
   output reg pslverr, // apb error, unmapped address
   input wire [3:0] small_timer_output_select, // small timer select
   input wire small_timer_out_pin, // small timer compare output
   output reg small_timer_clock_in, // pin 7.5 level to timer
   output reg small_timer_reset_in, // pin 7.4 level to timer
   input wire wide_timer_pwm_select_a, // channel a pwm (unused path)
   input wire [3:0] wide_timer_pwm_select, // pwm select d..a
   input wire [11:0] wide_timer_io_code, // io codes d,c,b,a 3 bits each
   input wire [3:0] wide_timer_out, // timer outputs d..a
   output reg [3:0] wide_timer_in, // pin levels 8.4..8.1 to timer
   output reg wide_timer_clock_in, // pin 8.0 level to timer
   input wire [6:4] p7_pin_in, // port 7 pin levels
   output reg [6:4] p7_pin_out, // port 7 pin drive value
   output reg [6:4] p7_pin_oe_n, // port 7 drive enable, low drives
   input wire [7:0] p8_pin_in, // port 8 pin levels
   output reg [7:0] p8_pin_out, // port 8 pin drive value
   output reg [7:0] p8_pin_oe_n // port 8 drive enable, low drives
);
   ////////////////////////////////////////////////////////////////////
   // registers and pin sampling
   reg [2:0] p7_dir_q;
   reg [2:0] p7_data_q;
   reg [7:0] p8_dir_q;
   reg [7:0] p8_data_q;
   wire [2:0] p7_sync;
   wire [7:0] p8_sync;
   wire wr_en;
   wire rd_en;
   reg [31:0] rdata_d;
   reg err_d;
   reg [2:0] p7_out_d;
   reg [2:0] p7_oe_d;
   reg [7:0] p8_out_d;
   reg [7:0] p8_oe_d;
   integer i;
   wire acc_ph;
   wire [7:0] p7_mix;
   wire [3:0] wt_pwm_en;
   wire [3:0] wt_own;
   genvar ch;

   // pin levels cross into pclk before anything reads them
   tsio_sync #(.WIDTH(3)) u_sync7
   (
      .pclk(pclk),
      .presetn(presetn),
      .d(p7_pin_in),
      .q(p7_sync)
   );

   tsio_sync #(.WIDTH(8)) u_sync8
   (
      .pclk(pclk),
      .presetn(presetn),
      .d(p8_pin_in),
      .q(p8_sync)
   );

   // one wait state: pready rises in the second access cycle, and the
   // write lands only at the edge where the master sees pready high
   assign acc_ph = psel & penable;
   assign wr_en = acc_ph & pwrite & pready;

   // read data caught at the edge that raises pready and then held, so the
   // master takes a settled word at the ready edge
   assign rd_en = acc_ph & ~pwrite & ~pready;

   // direction 1 returns latch, 0 returns pin level
   function [7:0] mix_read;
      input [7:0] dir;
      input [7:0] latch;
      input [7:0] pin;
      begin
         mix_read = (dir & latch) | (~dir & pin);
      end
   endfunction

   // timer output code 001 or 01x selects the timer output
   function code_is_out;
      input [2:0] code;
      begin
         code_is_out = ~code[2] & (code[1] | code[0]);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////
   // read mixing of port 7, only three bits carry meaning
   assign p7_mix = mix_read({5'h00, p7_dir_q}, {5'h00, p7_data_q},
                            {5'h00, p7_sync});

   ////////////////////////////////////////////////////////////////////
   // wide timer ownership of pins 8.4..8.1
   // channel a has no pwm mode, so its select bit is never looked at
   assign wt_pwm_en = {wide_timer_pwm_select[3:1], 1'b0};

   generate
      for (ch = 0; ch < 4; ch = ch + 1)
      begin : g_wide
         // pwm or an output code: the port setting is overridden
         assign wt_own[ch] = wt_pwm_en[ch] |
            code_is_out(wide_timer_io_code[3*ch +: 3]);
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////
   // apb slave
   always @*
   begin
      rdata_d = 32'h0000_0000;
      err_d = 1'b0;
      case (paddr)
         `TSIO_P7_DATA_ADDR:
         begin
            rdata_d[7:0] = `TSIO_P7_RSV_MASK;
            rdata_d[`TSIO_P7_MSB:`TSIO_P7_LSB] = p7_mix[2:0];
         end
         `TSIO_P8_DATA_ADDR:
            rdata_d[7:0] = mix_read(p8_dir_q, p8_data_q, p8_sync);
         `TSIO_P7_PIN_ADDR:
            rdata_d[2:0] = p7_sync;
         `TSIO_P8_PIN_ADDR:
            rdata_d[7:0] = p8_sync;
         // direction registers are write-only and read as zero
         `TSIO_P7_DIR_ADDR:
            rdata_d = 32'h0000_0000;
         `TSIO_P8_DIR_ADDR:
            rdata_d = 32'h0000_0000;
         default:
            err_d = 1'b1;
      endcase
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         // ready one cycle into the access phase, dropped after
         pready <= psel & penable & ~pready;
         pslverr <= psel & penable & ~pready & err_d;
         if (rd_en)
            prdata <= rdata_d;
      end
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         p7_dir_q <= `TSIO_P7_DIR_RST;
         p7_data_q <= `TSIO_P7_DATA_RST;
         p8_dir_q <= `TSIO_P8_DIR_RST;
         p8_data_q <= `TSIO_P8_DATA_RST;
      end
      else if (wr_en)
      begin
         case (paddr)
            `TSIO_P7_DIR_ADDR:
               p7_dir_q <= pwdata[`TSIO_P7_MSB:`TSIO_P7_LSB];
            `TSIO_P7_DATA_ADDR:
               p7_data_q <= pwdata[`TSIO_P7_MSB:`TSIO_P7_LSB];
            `TSIO_P8_DIR_ADDR:
               p8_dir_q <= pwdata[7:0];
            `TSIO_P8_DATA_ADDR:
               p8_data_q <= pwdata[7:0];
            default:
            begin
               p7_dir_q <= p7_dir_q;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // pin function muxing
   always @*
   begin
      // index 0 of the p7 vectors is pin 7.4
      p7_out_d = p7_data_q;
      p7_oe_d = p7_dir_q;
      if (small_timer_output_select != `TSIO_OS_PORT)
      begin
         p7_out_d[2] = small_timer_out_pin;
         p7_oe_d[2] = 1'b1;
      end
      p8_out_d = p8_data_q;
      p8_oe_d = p8_dir_q;
      // pins 8.1..8.4; timer setting applied last so it takes precedence
      for (i = 0; i < 4; i = i + 1)
      begin
         if (wt_own[i])
         begin
            p8_out_d[i+1] = wide_timer_out[i];
            p8_oe_d[i+1] = 1'b1;
         end
      end
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         p7_pin_out <= 3'h0;
         p7_pin_oe_n <= 3'h7;
         p8_pin_out <= 8'h00;
         p8_pin_oe_n <= 8'hff;
         small_timer_clock_in <= 1'b0;
         small_timer_reset_in <= 1'b0;
         wide_timer_in <= 4'h0;
         wide_timer_clock_in <= 1'b0;
      end
      else
      begin
         p7_pin_out <= p7_out_d;
         p7_pin_oe_n <= ~p7_oe_d;
         p8_pin_out <= p8_out_d;
         p8_pin_oe_n <= ~p8_oe_d;
         // timer inputs see the pin whatever the port setting
         small_timer_clock_in <= p7_sync[1];
         small_timer_reset_in <= p7_sync[0];
         wide_timer_in <= p8_sync[4:1];
         wide_timer_clock_in <= p8_sync[0];
      end
   end
endmodule // tsio_ports

/* testbench/tsio_checker.sv */
`timescale 1ns/10ps
module tsio_checker
(
   input wire pclk, // clock
   input wire presetn, // reset, low
   input wire pready, // apb ready
   input wire pslverr, // apb error
   input wire [3:0] small_timer_output_select, // select
   input wire small_timer_out_pin, // timer out
   input wire [6:4] p7_pin_in, // pins in
   input wire [6:4] p7_pin_out, // drive
   input wire [6:4] p7_pin_oe_n, // enable
   input wire small_timer_clock_in, // 7.5 level
   input wire [3:0] wide_timer_pwm_select, // pwm
   input wire [11:0] wide_timer_io_code, // codes
   input wire [7:0] p8_pin_in, // pins in
   input wire [7:0] p8_pin_oe_n, // enable
   input wire wide_timer_clock_in // 8.0 level
);
   wire [2:0] cd = wide_timer_io_code[11:9];
   wire tout = !wide_timer_pwm_select[3] && (cd == 3'h1 || cd[2:1] == 2'h1);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // sync path is three edges deep, five steady samples cover it
   sequence s_p75_still;
      $stable(p7_pin_in[5]) [*5];
   endsequence
   sequence s_p80_still;
      $stable(p8_pin_in[0]) [*5];
   endsequence
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("ready held too long");
   err_ready_a: assert property (pslverr |-> pready)
      else $error("error without ready");
   os_owns_oe_a: assert property (
      $past(small_timer_output_select) != 4'h0 |-> !p7_pin_oe_n[6])
      else $error("timer select lost pin");
   os_drive_a: assert property (
      $past(small_timer_output_select) != 4'h0 |->
      p7_pin_out[6] == $past(small_timer_out_pin))
      else $error("timer level not on pin");
   clk_in_a: assert property (
      s_p75_still |-> small_timer_clock_in == p7_pin_in[5])
      else $error("timer clock input stale");
   wclk_in_a: assert property (
      s_p80_still |-> wide_timer_clock_in == p8_pin_in[0])
      else $error("wide clock input stale");
   tout_oe_a: assert property ($past(tout) |-> !p8_pin_oe_n[4])
      else $error("timer code lost pin");
   pwm_oe_a: assert property (
      $past(wide_timer_pwm_select[3:2]) == 2'h3 |-> p8_pin_oe_n[4:3] == 2'h0)
      else $error("pwm lost pin");
endmodule // tsio_checker
bind tsio_ports tsio_checker i_chk
(
   .pclk, .presetn, .pready, .pslverr, .small_timer_output_select,
   .small_timer_out_pin, .p7_pin_in, .p7_pin_out, .p7_pin_oe_n,
   .small_timer_clock_in, .wide_timer_pwm_select, .wide_timer_io_code,
   .p8_pin_in, .p8_pin_oe_n, .wide_timer_clock_in
);

/* testbench/tb.sv */
`timescale 1ns/10ps
`include "tsio_regs.vh"
module tb;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic sto, stc, str, wclk, er;
   logic [11:0] paddr, code;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] os, pwm, wout, win;
   logic [6:4] p7i, p7o, p7e;
   logic [7:0] p8i, p8o, p8e;
   int error_cnt = 0;
   int n_tests = 0;
   int cyc = 0;
   tsio_ports i_dut
   (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr,
      .small_timer_output_select(os), .small_timer_out_pin(sto),
      .small_timer_clock_in(stc), .small_timer_reset_in(str),
      .wide_timer_pwm_select_a(1'b0), .wide_timer_pwm_select(pwm),
      .wide_timer_io_code(code), .wide_timer_out(wout),
      .wide_timer_in(win), .wide_timer_clock_in(wclk),
      .p7_pin_in(p7i), .p7_pin_out(p7o), .p7_pin_oe_n(p7e),
      .p8_pin_in(p8i), .p8_pin_out(p8o), .p8_pin_oe_n(p8e)
   );
   task chk(input logic [31:0] got, input logic [31:0] exp);
   begin
      n_tests++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("Error %0t: got %h exp %h", $time, got, exp);
      end
   end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
   begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // ready looked at mid-cycle once settled; request held to its edge
      do @(negedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
   end
   endtask
   task print_verdict;
   begin
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   end
   endtask
   task t_reset;
   begin
      repeat (4) @(posedge pclk);
      chk(p7e, 3'h7);
      chk(p8e, 8'hff);
      apb(1'b0, `TSIO_P7_DATA_ADDR, 32'h0);
      chk(rd, 32'haf);
      apb(1'b0, `TSIO_P8_DATA_ADDR, 32'h0);
      chk(rd, 32'h3d);
      $display("reset test done");
   end
   endtask
   task t_p7;
   begin
      apb(1'b1, `TSIO_P7_DIR_ADDR, 32'h40);
      apb(1'b1, `TSIO_P7_DATA_ADDR, 32'h70);
      apb(1'b0, `TSIO_P7_DATA_ADDR, 32'h0);
      chk(rd, 32'hef);
      chk(p7e, 3'b011);
      chk(p7o[6], 1'b1);
      apb(1'b0, `TSIO_P7_DIR_ADDR, 32'h0);
      chk(rd, 32'h0);
      apb(1'b1, `TSIO_P7_DIR_ADDR, 32'h70);
      apb(1'b1, `TSIO_P7_DATA_ADDR, 32'h0);
      apb(1'b0, `TSIO_P7_DATA_ADDR, 32'h0);
      chk(rd, 32'h8f);
      $display("port 7 test done");
   end
   endtask
   task t_os;
   begin
      apb(1'b1, `TSIO_P7_DIR_ADDR, 32'h0);
      os <= 4'h5;
      repeat (4) @(posedge pclk);
      chk(p7e[6], 1'b0);
      chk(p7o[6], 1'b1);
      chk({stc, str}, 2'b10);
      os <= 4'h0;
      repeat (4) @(posedge pclk);
      chk(p7e[6], 1'b1);
      $display("timer select test done");
   end
   endtask
   task t_p8;
   begin
      apb(1'b1, `TSIO_P8_DIR_ADDR, 32'hf0);
      apb(1'b1, `TSIO_P8_DATA_ADDR, 32'ha5);
      apb(1'b0, `TSIO_P8_DATA_ADDR, 32'h0);
      chk(rd, 32'had);
      chk(p8e, 8'h0f);
      chk(p8o[7:4], 4'ha);
      chk({win, wclk}, 5'h1d);
      $display("port 8 test done");
   end
   endtask
   task t_wide;
      logic [3:0] e;
   begin
      apb(1'b1, `TSIO_P8_DIR_ADDR, 32'h0);
      // every io code applied to channels d..a at once
      for (int i = 0; i < 8; i++)
      begin
         code <= {4{i[2:0]}};
         repeat (3) @(posedge pclk);
         e = (i >= 1 && i <= 3) ? 4'h0 : 4'hf;
         chk(p8e[4:1], e);
         if (i == 1) chk(p8o[4:1], 4'ha);
      end
      pwm <= 4'hf;
      code <= 12'h0;
      repeat (3) @(posedge pclk);
      chk(p8e[4:1], 4'h1);
      $display("wide timer test done");
   end
   endtask
   task t_err;
   begin
      apb(1'b0, 12'h018, 32'h0);
      chk(er, 1'b1);
      chk(rd, 32'h0);
      $display("unmapped test done");
   end
   endtask
   initial
   begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   always @(posedge pclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 3000)
      begin
         error_cnt++;
         print_verdict;
      end
   end
   initial
   begin
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      os = 4'h0;
      sto = 1'b1;
      pwm = 4'h0;
      code = 12'h0;
      wout = 4'ha;
      p7i = 3'b010;
      p8i = 8'h3d;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      t_reset;
      t_p7;
      t_os;
      t_p8;
      t_wide;
      t_err;
      print_verdict;
   end
endmodule // tb
